// file: inc/scwl_pkg.sv
// Package with offsets, field positions and reset values for the control word block
package scwl_pkg;
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  CTRL_ONE_OFF    = 4'h0;
    localparam logic [3:0]  STATUS_OFF      = 4'h4;
    localparam int          BIT_LSB_FIRST   = 0;
    localparam int          BIT_SDIO_IN     = 1;
    localparam int          BIT_EXTPD_FAST  = 3;
    localparam int          BIT_REF_PD      = 5;
    localparam int          BIT_DAC_PD      = 6;
    localparam int          BIT_DIG_PD      = 7;
    localparam int          BIT_SK_EN       = 8;
    localparam int          BIT_SK_AUTO     = 9;
    localparam int          BIT_PHASE_CLR   = 11;
    localparam int          BIT_RAMP_CLR    = 12;
    localparam int          BIT_PHASE_AUTO  = 13;
    localparam int          BIT_RAMP_AUTO   = 14;
    localparam logic [14:0] CTRL_RESET      = 15'h0008;
    localparam logic [14:0] CTRL_MASK       = 15'h7BEB;
    localparam logic [14:0] IMMEDIATE_MASK  = 15'h00A0;
    localparam int          SYNC_STAGES     = 3;
endpackage : scwl_pkg

// file: logic/scwl_sync.sv
// Three-stage input synchroniser with agreement filter
module scwl_sync #(
    parameter int STAGES = scwl_pkg::SYNC_STAGES                    // Flops in the chain, 3 or more
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic [STAGES-1:0] stg_r;

    // Shorter chains leave no agreeing pair behind the first flop
    if (STAGES < 3) begin : g_bad_stages
        $error("scwl_sync: chain shorter than three flops is not supported");
    end

    // Shift chain; output changes once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stg_r <= '0;
            dout  <= 1'b0;
        end else begin
            stg_r <= {stg_r[STAGES-2:0], din};
            if (stg_r[STAGES-2] == stg_r[STAGES-1]) begin
                dout <= stg_r[STAGES-1];
            end
        end
    end
endmodule : scwl_sync

// file: logic/scwl_ctrl.sv
// Control word low half: staged register, update transfer, clear and power controls
module scwl_ctrl #(
    parameter int DATA_W = 32                                       // Bus width, 16 or more
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [scwl_pkg::ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0]          wdata,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output logic      [DATA_W-1:0]          rdata,
    input  wire logic                       io_update_pin,
    input  wire logic [2:0]                 profile_select,
    input  wire logic                       external_powerdown_pin,
    output logic                            ramp_acc_clear,
    output logic                            phase_acc_clear,
    output logic                            shift_keying_enable,
    output logic                            shift_keying_auto,
    output logic                            amp_scale_enable,
    output logic                            digital_clk_gate,
    output logic                            dac_powerdown,
    output logic                            ref_clk_powerdown,
    output logic                            full_powerdown,
    output logic                            fast_powerdown,
    output logic                            sdio_input_only,
    output logic                            serial_lsb_first
);
    logic [14:0] staged_r;
    logic [14:0] active_r;
    logic [14:0] active_nxt;
    logic [2:0]  ps_sync;
    logic [2:0]  ps_prev_r;
    logic        upd_sync;
    logic        upd_prev_r;
    logic        pd_sync;
    logic        ramp_pulse_r;
    logic        phase_pulse_r;
    logic [DATA_W-1:0] rdata_r;
    logic        ramp_clr_r;
    logic        phase_clr_r;
    logic        sk_en_r;
    logic        sk_auto_r;
    logic        amp_en_r;
    logic        dig_pd_r;
    logic        dac_pd_r;
    logic        ref_pd_r;
    logic        full_pd_r;
    logic        fast_pd_r;
    logic        sdio_in_r;
    logic        lsb_first_r;
    localparam int PAD_W = DATA_W - $bits(scwl_pkg::CTRL_RESET);    // Zero bits above the word

    // Refuse bus widths that leave no room for the word and its zero pad
    if (DATA_W < 16) begin : g_bad_width
        $error("scwl_ctrl: bus width below 16 bits is not supported");
    end

    // Address compare shared by every register select
    function automatic logic addr_hit(
        input logic [scwl_pkg::ADDR_W-1:0] a,
        input logic [scwl_pkg::ADDR_W-1:0] off
    );
        return a == off;
    endfunction : addr_hit

    // Pin inputs brought into the clock domain
    scwl_sync u_sync_upd (.clk(clk), .rst_n(rst_n), .din(io_update_pin), .dout(upd_sync));
    scwl_sync u_sync_pd  (.clk(clk), .rst_n(rst_n), .din(external_powerdown_pin),
                          .dout(pd_sync));
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ps
            scwl_sync u_sync_ps (.clk(clk), .rst_n(rst_n), .din(profile_select[gi]),
                                 .dout(ps_sync[gi]));
        end
    endgenerate

    // Update event: rising update strobe or any profile change
    wire upd_rise  = upd_sync & ~upd_prev_r;
    wire ps_change = (ps_sync != ps_prev_r);
    wire upd_event = upd_rise | ps_change;

    // Decode of the bus
    wire ctrl_sel  = addr_hit(addr, scwl_pkg::CTRL_ONE_OFF);
    wire stat_sel  = addr_hit(addr, scwl_pkg::STATUS_OFF);
    wire ctrl_wr   = wr_en & ctrl_sel;
    wire [14:0] wr_val = wdata[14:0] & scwl_pkg::CTRL_MASK;

    // Next active value: staged bits move on update, immediate bits always
    wire [14:0] staged_eff = ctrl_wr ? wr_val : staged_r;
    always_comb begin
        active_nxt = upd_event ? staged_r : active_r;
        active_nxt = (active_nxt & ~scwl_pkg::IMMEDIATE_MASK)
                   | (staged_eff & scwl_pkg::IMMEDIATE_MASK);
    end

    // Staged register written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            staged_r <= scwl_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            staged_r <= wr_val;
        end
    end

    // Active register, edge history and autoclear pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_r      <= scwl_pkg::CTRL_RESET;
            upd_prev_r    <= 1'b0;
            ps_prev_r     <= 3'h0;
            ramp_pulse_r  <= 1'b0;
            phase_pulse_r <= 1'b0;
        end else begin
            active_r      <= active_nxt;
            upd_prev_r    <= upd_sync;
            ps_prev_r     <= ps_sync;
            ramp_pulse_r  <= upd_event & staged_r[scwl_pkg::BIT_RAMP_AUTO];
            phase_pulse_r <= upd_event & staged_r[scwl_pkg::BIT_PHASE_AUTO];
        end
    end

    // Next values of the output flops, so they move in step with active_r
    wire ramp_clr_nxt  = (upd_event & staged_r[scwl_pkg::BIT_RAMP_AUTO])
                       | active_nxt[scwl_pkg::BIT_RAMP_CLR];
    wire phase_clr_nxt = (upd_event & staged_r[scwl_pkg::BIT_PHASE_AUTO])
                       | active_nxt[scwl_pkg::BIT_PHASE_CLR];
    wire sk_auto_nxt   = active_nxt[scwl_pkg::BIT_SK_EN]
                       & active_nxt[scwl_pkg::BIT_SK_AUTO];
    wire full_pd_nxt   = pd_sync & ~active_nxt[scwl_pkg::BIT_EXTPD_FAST];
    wire fast_pd_nxt   = pd_sync & active_nxt[scwl_pkg::BIT_EXTPD_FAST];

    // Clear and keying flops; clears are a one-cycle pulse or a static hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_clr_r  <= 1'b0;
            phase_clr_r <= 1'b0;
            sk_en_r     <= 1'b0;
            sk_auto_r   <= 1'b0;
            amp_en_r    <= 1'b0;
        end else begin
            ramp_clr_r  <= ramp_clr_nxt;
            phase_clr_r <= phase_clr_nxt;
            sk_en_r     <= active_nxt[scwl_pkg::BIT_SK_EN];
            sk_auto_r   <= sk_auto_nxt;
            amp_en_r    <= active_nxt[scwl_pkg::BIT_SK_EN];
        end
    end

    // Power and serial port flops; the pin choice follows the synced level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dig_pd_r    <= 1'b0;
            dac_pd_r    <= 1'b0;
            ref_pd_r    <= 1'b0;
            full_pd_r   <= 1'b0;
            fast_pd_r   <= 1'b0;
            sdio_in_r   <= 1'b0;
            lsb_first_r <= 1'b0;
        end else begin
            dig_pd_r    <= active_nxt[scwl_pkg::BIT_DIG_PD];
            dac_pd_r    <= active_nxt[scwl_pkg::BIT_DAC_PD];
            ref_pd_r    <= active_nxt[scwl_pkg::BIT_REF_PD];
            full_pd_r   <= full_pd_nxt;
            fast_pd_r   <= fast_pd_nxt;
            sdio_in_r   <= active_nxt[scwl_pkg::BIT_SDIO_IN];
            lsb_first_r <= active_nxt[scwl_pkg::BIT_LSB_FIRST];
        end
    end

    // Ports driven straight from the output flops
    assign ramp_acc_clear      = ramp_clr_r;
    assign phase_acc_clear     = phase_clr_r;
    assign shift_keying_enable = sk_en_r;
    assign shift_keying_auto   = sk_auto_r;
    assign amp_scale_enable    = amp_en_r;
    assign digital_clk_gate    = dig_pd_r;
    assign dac_powerdown       = dac_pd_r;
    assign ref_clk_powerdown   = ref_pd_r;
    assign full_powerdown      = full_pd_r;
    assign fast_powerdown      = fast_pd_r;
    assign sdio_input_only     = sdio_in_r;
    assign serial_lsb_first    = lsb_first_r;

    // Read data: staged value, or active state at the status offset
    wire [DATA_W-1:0] rd_mux = ctrl_sel ? {{PAD_W{1'b0}}, staged_r}
                             : stat_sel ? {{PAD_W{1'b0}}, active_r} : '0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rd_en ? rd_mux : '0;
        end
    end
    assign rdata = rdata_r;

    // Assertions
    a_ramp_auto_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (upd_event && staged_r[scwl_pkg::BIT_RAMP_AUTO]) |=> ramp_acc_clear)
        else $error("ramp autoclear pulse missing");
    a_pulse_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        (ramp_pulse_r && !upd_event) |=> !ramp_pulse_r)
        else $error("ramp autoclear pulse too long");
    a_no_event_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !upd_event |=> ((active_r & ~scwl_pkg::IMMEDIATE_MASK)
                        == ($past(active_r) & ~scwl_pkg::IMMEDIATE_MASK)))
        else $error("staged bits moved without update");
    a_phase_auto_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (upd_event && staged_r[scwl_pkg::BIT_PHASE_AUTO]) |=> phase_acc_clear)
        else $error("phase autoclear missing");
    a_ramp_hold: assert property (@(posedge clk) disable iff (!rst_n)
        active_r[scwl_pkg::BIT_RAMP_CLR] |-> ramp_acc_clear)
        else $error("ramp hold missing");
    a_phase_hold: assert property (@(posedge clk) disable iff (!rst_n)
        active_r[scwl_pkg::BIT_PHASE_CLR] |-> phase_acc_clear)
        else $error("phase hold missing");
    a_keying_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !shift_keying_enable |-> !shift_keying_auto)
        else $error("keying mode without enable");
    a_immediate_bits: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr |=> (digital_clk_gate == $past(wr_val[scwl_pkg::BIT_DIG_PD])))
        else $error("digital power-down not immediate");
    a_update_moves: assert property (@(posedge clk) disable iff (!rst_n)
        (upd_event && !ctrl_wr) |=> (active_r == $past(staged_r)))
        else $error("update did not transfer");
    a_open_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (staged_r & ~scwl_pkg::CTRL_MASK) == 15'h0000)
        else $error("open bit set");

    // Clear paths: pulses tied to events, holds moved only on update
    a_ramp_pulse_event: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ramp_pulse_r) |-> $past(upd_event))
        else $error("ramp pulse without update");
    a_ramp_clr_update: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(active_r[scwl_pkg::BIT_RAMP_CLR]) |-> $past(upd_event))
        else $error("ramp clear bit moved without update");
    a_phase_clr_update: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(active_r[scwl_pkg::BIT_PHASE_CLR]) |-> $past(upd_event))
        else $error("phase clear bit moved without update");
    a_phase_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        (phase_pulse_r && !upd_event) |=> !phase_pulse_r)
        else $error("phase autoclear pulse too long");
    a_ramp_release: assert property (@(posedge clk) disable iff (!rst_n)
        (!active_r[scwl_pkg::BIT_RAMP_CLR] && !ramp_pulse_r) |-> !ramp_acc_clear)
        else $error("ramp clear without cause");
    a_phase_release: assert property (@(posedge clk) disable iff (!rst_n)
        (!active_r[scwl_pkg::BIT_PHASE_CLR] && !phase_pulse_r) |-> !phase_acc_clear)
        else $error("phase clear without cause");

    // Keying, power and serial port levels, and open bits in read data
    a_keying_mode: assert property (@(posedge clk) disable iff (!rst_n)
        shift_keying_enable |-> (shift_keying_auto == active_r[scwl_pkg::BIT_SK_AUTO]))
        else $error("keying mode differs from mode bit");
    a_amp_enable: assert property (@(posedge clk) disable iff (!rst_n)
        amp_scale_enable == active_r[scwl_pkg::BIT_SK_EN])
        else $error("amplitude enable differs from keying enable");
    a_digital_level: assert property (@(posedge clk) disable iff (!rst_n)
        digital_clk_gate == active_r[scwl_pkg::BIT_DIG_PD])
        else $error("digital power-down level wrong");
    a_dac_level: assert property (@(posedge clk) disable iff (!rst_n)
        dac_powerdown == active_r[scwl_pkg::BIT_DAC_PD])
        else $error("converter power-down level wrong");
    a_dac_on_update: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(dac_powerdown) |-> $past(upd_event))
        else $error("converter power-down moved without update");
    a_ref_immediate: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr |=> (ref_clk_powerdown == $past(wr_val[scwl_pkg::BIT_REF_PD])))
        else $error("reference power-down not immediate");
    a_full_select: assert property (@(posedge clk) disable iff (!rst_n)
        full_powerdown |-> !active_r[scwl_pkg::BIT_EXTPD_FAST])
        else $error("full power-down with fast mode chosen");
    a_fast_select: assert property (@(posedge clk) disable iff (!rst_n)
        fast_powerdown |-> active_r[scwl_pkg::BIT_EXTPD_FAST])
        else $error("fast power-down with full mode chosen");
    a_pd_follows_pin: assert property (@(posedge clk) disable iff (!rst_n)
        $past(pd_sync) |-> (full_powerdown || fast_powerdown))
        else $error("power-down pin ignored");
    a_sdio_level: assert property (@(posedge clk) disable iff (!rst_n)
        sdio_input_only == active_r[scwl_pkg::BIT_SDIO_IN])
        else $error("serial data direction wrong");
    a_order_level: assert property (@(posedge clk) disable iff (!rst_n)
        serial_lsb_first == active_r[scwl_pkg::BIT_LSB_FIRST])
        else $error("serial bit order wrong");
    a_read_open_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_en && ctrl_sel) |=> ((rdata & ~{{PAD_W{1'b0}}, scwl_pkg::CTRL_MASK}) == '0))
        else $error("open bit read back set");
endmodule : scwl_ctrl

// file: tb/scwl_host_model.sv
// Host side model driving the update strobe and profile pins
module scwl_host_model (
    input  wire logic       clk,
    input  wire logic       upd_req,
    input  wire logic       prof_req,
    output logic            io_update_pin,
    output logic      [2:0] profile_select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_r = 3'h0;
    // Strobe stretched to four cycles so the input filter keeps it
    always_ff @(posedge clk) begin
        if (upd_req) begin
            cnt_r <= 3'h4;
        end else if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
        end
    end
    assign io_update_pin = (cnt_r != 3'h0);
    logic [2:0] prof_r = 3'h0;
    // Each request moves to the next profile
    always_ff @(posedge clk) begin
        if (prof_req) prof_r <= prof_r + 3'h1;
    end
    assign profile_select = prof_r;
endmodule : scwl_host_model

// file: tb/synth_control_word_low_bench.sv
// Self-checking bench for the control word low half
module synth_control_word_low_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic        upd_req = 1'b0, prof_req = 1'b0, pd_pin = 1'b0, upd;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [2:0]  ps;
    logic        rac, pac, ske, ska, ase, dcg, dpd, rpd, fpd, qpd, sdi, lsb;
    int          n_fail = 0, checks_done = 0, hits, hp;
    scwl_ctrl scwl_ctrl_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .io_update_pin(upd),
        .profile_select(ps), .external_powerdown_pin(pd_pin), .ramp_acc_clear(rac),
        .phase_acc_clear(pac), .shift_keying_enable(ske), .shift_keying_auto(ska),
        .amp_scale_enable(ase), .digital_clk_gate(dcg), .dac_powerdown(dpd),
        .ref_clk_powerdown(rpd), .full_powerdown(fpd), .fast_powerdown(qpd),
        .sdio_input_only(sdi), .serial_lsb_first(lsb));
    scwl_host_model scwl_host_model_inst (.clk(clk), .upd_req(upd_req),
        .prof_req(prof_req), .io_update_pin(upd), .profile_select(ps));
    // Clock
    initial forever #5 clk = ~clk;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 cmp(rdata, exp);
    endtask : rd
    // Update by strobe or profile change, counting clear pulses
    task automatic update(input logic prof);
        @(posedge clk);
        if (prof) prof_req <= 1'b1;
        else upd_req <= 1'b1;
        @(posedge clk);
        prof_req <= 1'b0;
        upd_req <= 1'b0;
        hits = 0;
        hp = 0;
        repeat (12) begin
            @(posedge clk);
            #1 hits += rac;
            hp += pac;
        end
    endtask : update
    task automatic results;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(4'h0, 32'h8);
        rd(4'h4, 32'h8);
        wr(4'h0, 32'hFFFF_FFFF);
        #1 cmp(dcg, 1);
        cmp(rpd, 1);
        cmp(dpd, 0);
        cmp(rac, 0);
        rd(4'h0, 32'h7BEB);
        rd(4'h8, 32'h0);
        update(1'b0);
        rd(4'h4, 32'h7BEB);
        cmp({rac, pac}, 2'h3);
        cmp({ske, ska, ase, dpd, sdi, lsb}, 6'h3F);
        @(posedge clk);
        pd_pin <= 1'b1;
        repeat (6) @(posedge clk);
        #1 cmp({fpd, qpd}, 2'h1);
        wr(4'h0, 32'h0000_6000);
        update(1'b0);
        cmp({rac, pac}, 2'h0);
        update(1'b1);
        cmp(hits, 1);
        cmp(hp, 1);
        wr(4'h0, 32'h0000_0200);
        update(1'b0);
        cmp(hits, 0);
        cmp(hp, 0);
        cmp({ska, ase, dcg, rpd}, 4'h0);
        cmp({fpd, qpd}, 2'h2);
        results();
    end
    // Watchdog
    initial begin
        #200_000;
        n_fail++;
        results();
    end
endmodule : synth_control_word_low_bench
